// file: pmsup_pins.sv
// Notes on behaviour
// RL1: Any set unmasked flag pulls interrupt line low.
// RL2: Line releases after host reads causing flag.
// RL3: Masked sources never assert the interrupt.
// RL4: Interrupt pin is open-drain, active low.
// RL5: Shutdown input low turns all outputs off; the code keeps button_pressed live and drives defaults_load high.
// RL6: After shutdown release, wait then default restart.
// RL7: All-rails-good low when any rail fails.
// RL8: Linear-good follows linear regulators one, two.
// RL9: Power request high starts rail sequence.
// RL10: Wake pin pulls low on power-on event.
// RL11: Button input low means pressed.
// RL12: Interrupt holds while unmasked flags pend.
// RL13: Shutdown, enable, button inputs are synchronised.
module pmsup_pins #(
	parameter int unsigned RESTART_CYCLES = pmsup_pkg::RESTART_CYCLES,
	parameter int unsigned SRC_W          = pmsup_pkg::IRQ_SRC_W
) (
	input  wire logic                          core_clk,
	input  wire logic                          rst_n,
	input  wire logic                          hw_shutdown_n,
	input  wire logic                          power_on_request,
	input  wire logic                          button_press_n,
	input  wire logic [pmsup_pkg::RAIL_W-1:0]  rail_in_reg,
	input  wire pmsup_pkg::pmsup_irq_s         irq_ctl,
	output logic [SRC_W-1:0]                   irq_flags,
	output logic                               irq_request_n_out,
	output logic                               irq_request_n_oe,
	output logic                               wake_indication_n_out,
	output logic                               wake_indication_n_oe,
	output logic                               all_rails_good,
	output logic                               linear_regs_good,
	output logic [pmsup_pkg::RAIL_W-1:0]       rail_enable,
	output logic                               button_pressed,
	output logic                               defaults_load
);

	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	logic [pmsup_pkg::SYNC_W-1:0] pins_raw;
	logic [pmsup_pkg::SYNC_W-1:0] pins_s;
	logic                         shdn_n_s;
	logic                         pwren_s;

	// All three pins cross into core_clk before use. [RL13]
	assign pins_raw = {button_press_n, power_on_request, hw_shutdown_n};

	pmsup_sync #(
		.WIDTH (pmsup_pkg::SYNC_W),
		.INIT  (pmsup_pkg::SYNC_RESET)
	) u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.async_in (pins_raw),
		.sync_out (pins_s)
	);

	assign shdn_n_s = pins_s[pmsup_pkg::SYN_SHDN];
	assign pwren_s  = pins_s[pmsup_pkg::SYN_PWREN];

	// ****************************************************************
	// Power state machine
	// ****************************************************************
	localparam int unsigned CNT_W = $clog2(RESTART_CYCLES + 1);

	pmsup_pkg::pmsup_state_e state_q;
	pmsup_pkg::pmsup_state_e state_d;
	logic [CNT_W-1:0]        cnt_q;
	logic [CNT_W-1:0]        cnt_d;
	logic                    wake_q;
	logic                    wake_d;
	logic                    btn_q;
	logic                    btn_d;

	// Shutdown has priority over everything; the restart delay counts
	// only while the pin stays high, so a bounce starts it over.
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		wake_d  = wake_q;
		btn_d   = !pins_s[pmsup_pkg::SYN_BUTTON];   // [RL11]
		case (state_q)
			pmsup_pkg::PMSUP_OFF: begin
				if (!shdn_n_s) begin
					state_d = pmsup_pkg::PMSUP_RESTART;
					cnt_d   = '0;
				end else if (pwren_s) begin
					state_d = pmsup_pkg::PMSUP_RUN;   // [RL9]
					wake_d  = 1'b1;                   // [RL10]
				end
			end
			pmsup_pkg::PMSUP_RUN: begin
				if (!shdn_n_s) begin
					state_d = pmsup_pkg::PMSUP_RESTART;   // [RL5]
					cnt_d   = '0;
				end else if (!pwren_s) begin
					state_d = pmsup_pkg::PMSUP_OFF;
				end
			end
			pmsup_pkg::PMSUP_RESTART: begin
				if (!shdn_n_s) begin
					cnt_d = '0;
				end else if (cnt_q == CNT_W'(RESTART_CYCLES - 1)) begin
					state_d = pmsup_pkg::PMSUP_OFF;   // [RL6]
				end else begin
					cnt_d = cnt_q + CNT_W'(1);
				end
			end
			default: begin
				state_d = pmsup_pkg::PMSUP_OFF;
			end
		endcase
		// The wake pulse is held until host reads flags or the state leaves PMSUP_RUN.
		if (state_q != pmsup_pkg::PMSUP_RUN || |irq_ctl.read_ack) begin
			if (!(state_q == pmsup_pkg::PMSUP_OFF && state_d ==
				pmsup_pkg::PMSUP_RUN)) begin
				wake_d = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= pmsup_pkg::PMSUP_OFF;
			cnt_q   <= '0;
			wake_q  <= 1'b0;
			btn_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			wake_q  <= wake_d;
			btn_q   <= btn_d;
		end
	end

	// ****************************************************************
	// Interrupt flags
	// ****************************************************************
	logic [SRC_W-1:0] flag_q;
	logic [SRC_W-1:0] flag_d;
	logic             irq_q;
	logic             irq_d;
	logic             running;

	assign running = (state_q == pmsup_pkg::PMSUP_RUN);

	// A set in the same cycle as its read wins, so no event is lost.
	// Flags return to their default while shut down.
	always_comb begin
		flag_d = (flag_q & ~irq_ctl.read_ack) | irq_ctl.set;   // [RL2]
		if (!running) begin
			flag_d = '0;
		end
		irq_d = |(flag_d & ~irq_ctl.mask);   // [RL1] [RL3] [RL12]
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= '0;
			irq_q  <= 1'b0;
		end else begin
			flag_q <= flag_d;
			irq_q  <= irq_d;
		end
	end

	// ****************************************************************
	// Rail outputs and power-good
	// ****************************************************************
	logic [pmsup_pkg::RAIL_W-1:0] en_q;
	logic [pmsup_pkg::RAIL_W-1:0] en_d;
	logic                         pg_q;
	logic                         pg_d;
	logic                         lpg_q;
	logic                         lpg_d;

	// Rail status is a registered analog comparator result; a disabled
	// rail counts as out of regulation.
	always_comb begin
		en_d  = running ? '1 : '0;   // [RL9] [RL5]
		pg_d  = running && (&rail_in_reg);   // [RL7]
		lpg_d = running && rail_in_reg[pmsup_pkg::RAIL_LIN1]
			&& rail_in_reg[pmsup_pkg::RAIL_LIN2];   // [RL8]
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q  <= '0;
			pg_q  <= 1'b0;
			lpg_q <= 1'b0;
		end else begin
			en_q  <= en_d;
			pg_q  <= pg_d;
			lpg_q <= lpg_d;
		end
	end

	// Open-drain pins: out is always low, enable pulls. [RL4] [RL10]
	assign irq_request_n_out     = 1'b0;
	assign irq_request_n_oe      = irq_q;
	assign wake_indication_n_out = 1'b0;
	assign wake_indication_n_oe  = wake_q;
	assign all_rails_good        = pg_q;
	assign linear_regs_good      = lpg_q;
	assign rail_enable           = en_q;
	assign irq_flags             = flag_q;
	assign button_pressed        = btn_q;
	assign defaults_load         = !running;

	// ****************************************************************
	// Checks
	// ****************************************************************
	irq_follows_flags_a: assert property (   // [RL1]
		@(posedge core_clk) disable iff (!rst_n)
		running && |(flag_q & ~irq_ctl.read_ack & ~irq_ctl.mask)
		|=> irq_request_n_oe)
		else $error("interrupt not asserted for pending flag");

	irq_masked_quiet_a: assert property (   // [RL3]
		@(posedge core_clk) disable iff (!rst_n)
		(irq_ctl.set != '0 && (irq_ctl.set & ~irq_ctl.mask) == '0
		&& (flag_q & ~irq_ctl.mask) == '0 && $stable(irq_ctl.mask))
		|=> !irq_request_n_oe)
		else $error("masked source asserted interrupt");

	irq_read_release_a: assert property (   // [RL2]
		@(posedge core_clk) disable iff (!rst_n)
		(irq_ctl.read_ack == flag_q && irq_ctl.set == '0
		&& flag_q != '0) |=> flag_q == '0)
		else $error("read did not clear flags");

	irq_open_drain_a: assert property (   // [RL4]
		@(posedge core_clk) disable iff (!rst_n)
		!irq_request_n_out && !wake_indication_n_out)
		else $error("open-drain pin driven high");

	shdn_outputs_off_a: assert property (   // [RL5]
		@(posedge core_clk) disable iff (!rst_n)
		!shdn_n_s |=> ##1 (rail_enable == '0 && !all_rails_good))
		else $error("outputs alive during shutdown");

	restart_delay_a: assert property (   // [RL6]
		@(posedge core_clk) disable iff (!rst_n)
		(state_q == pmsup_pkg::PMSUP_RESTART && cnt_q != '0)
		|-> rail_enable == '0)
		else $error("rails enabled during restart delay");

	all_rails_good_any_rail_a: assert property (   // [RL7]
		@(posedge core_clk) disable iff (!rst_n)
		!(&rail_in_reg) |=> !all_rails_good)
		else $error("power good high with failed rail");

	lin_good_pair_a: assert property (   // [RL8]
		@(posedge core_clk) disable iff (!rst_n)
		(running && $past(running) && rail_in_reg[pmsup_pkg::RAIL_LIN1]
		&& rail_in_reg[pmsup_pkg::RAIL_LIN2] && $stable(running))
		|=> linear_regs_good)
		else $error("linear good low with both regulators good");

	power_request_a: assert property (   // [RL9]
		@(posedge core_clk) disable iff (!rst_n)
		(state_q == pmsup_pkg::PMSUP_OFF && shdn_n_s && pwren_s)
		|=> ##1 rail_enable == '1)
		else $error("power request did not enable rails");

	wake_on_power_a: assert property (   // [RL10]
		@(posedge core_clk) disable iff (!rst_n)
		(state_q == pmsup_pkg::PMSUP_OFF && shdn_n_s && pwren_s)
		|=> wake_indication_n_oe)
		else $error("no wake indication on power-on");

	button_level_a: assert property (   // [RL11] [RL13]
		@(posedge core_clk) disable iff (!rst_n)
		$past(pins_s[pmsup_pkg::SYN_BUTTON]) == !button_pressed)
		else $error("button state mismatch");

endmodule : pmsup_pins

// file: pmsup_pkg.sv
package pmsup_pkg;

	// ****************************************************************
	// Sizes and timing
	// ****************************************************************
	localparam int unsigned CLK_FREQ_HZ    = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned RESTART_MS     = 1000;
	localparam int unsigned RESTART_CYCLES =
		(RESTART_MS * (CLK_FREQ_HZ / 1000));
	localparam int unsigned IRQ_SRC_W      = 8;
	localparam int unsigned RAIL_W         = 7;
	localparam int unsigned SYNC_W         = 3;

	// Rail positions within the rail vectors.
	localparam int unsigned RAIL_BUCK1 = 0;
	localparam int unsigned RAIL_BUCK2 = 1;
	localparam int unsigned RAIL_BUCK3 = 2;
	localparam int unsigned RAIL_LIN1  = 3;
	localparam int unsigned RAIL_LIN2  = 4;
	localparam int unsigned RAIL_LIN3  = 5;
	localparam int unsigned RAIL_LIN4  = 6;

	// Positions of the synchronised pin inputs.
	localparam int unsigned SYN_SHDN   = 0;
	localparam int unsigned SYN_PWREN  = 1;
	localparam int unsigned SYN_BUTTON = 2;

	// Synchroniser preset: shutdown and button idle high, request idle
	// low, so reset release never looks like a power-up request.
	localparam logic [SYNC_W-1:0] SYNC_RESET = 3'h5;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		PMSUP_OFF     = 3'h1,
		PMSUP_RUN     = 3'h2,
		PMSUP_RESTART = 3'h4
	} pmsup_state_e;

	// Open-drain pin as two signals; the line is low when enabled.
	typedef struct packed {
		logic out;
		logic oe;
	} pmsup_od_s;

	// Interrupt side-band: flag capture and host read acknowledgement.
	typedef struct packed {
		logic [IRQ_SRC_W-1:0] set;
		logic [IRQ_SRC_W-1:0] mask;
		logic [IRQ_SRC_W-1:0] read_ack;
	} pmsup_irq_s;

endpackage : pmsup_pkg

// file: pmsup_sync.sv
// Two-flop synchroniser for a group of pin inputs.
module pmsup_sync #(
	parameter int unsigned WIDTH = 3,
	parameter logic [WIDTH-1:0] INIT = '1
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// Only the second stage reads the first, to contain metastability.
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// Both stages preset so released pins look inactive after reset.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= INIT;
			sync_q <= INIT;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule : pmsup_sync

// file: pmsup_host_model.sv
// Host side of the interrupt line: reads flags one at a time after a delay.
module pmsup_host_model (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       irq_line,
	input  wire logic       reading,
	input  wire logic [3:0] delay,
	input  wire logic [7:0] flags,
	output logic      [7:0] read_ack
);
	timeunit 1ns;
	timeprecision 1ns;

	int cnt;

	// The host only reads while the line is pulled low, and reads the lowest
	// pending flag; the delay lets a slow host leave the request standing.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			read_ack <= '0;
			cnt <= 0;
		end else begin
			read_ack <= '0;
			if (reading && irq_line === 1'b0 && read_ack == '0) begin
				if (cnt >= delay) begin
					read_ack <= flags & (~flags + 8'h01);
					cnt <= 0;
				end else begin
					cnt <= cnt + 1;
				end
			end else begin
				cnt <= 0;
			end
		end
	end
endmodule : pmsup_host_model

// file: pmsup_pins_bench.sv
// Self-checking bench for the supervisory pin logic.
module pmsup_pins_bench;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int RC = 20;
	localparam logic [20:0] M_FLG = 21'h1FE000, M_IRQ = 21'h001000;
	localparam logic [20:0] M_WAKE = 21'h000800, M_AG = 21'h000400;
	localparam logic [20:0] M_LG = 21'h000200, M_RAIL = 21'h0001FC;
	localparam logic [20:0] M_BTN = 21'h000002, M_ALL = 21'h1FFFFF;

	logic        core_clk, rst_n, hw_shutdown_n, power_on_request;
	logic        button_press_n, reading, irq_oe, irq_out, wake_oe;
	logic        wake_out, all_good, lin_good, btn, dflt;
	logic [3:0]  dly;
	logic [6:0]  rail_in_reg, rail_enable;
	logic [7:0]  irq_set, irq_mask, host_ack, irq_flags, s, m, f;
	logic [20:0] obs;
	logic [31:0] seed, r;
	logic [41:0] notes[$], nt;
	int          n_mismatch, comparisons, n;
	wire         irq_line = irq_oe ? irq_out : 1'b1;
	wire         wake_line = wake_oe ? wake_out : 1'b1;

	assign obs = {irq_flags, irq_oe, wake_oe, all_good, lin_good,
		rail_enable, btn, dflt};

	pmsup_pins #(.RESTART_CYCLES(RC)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .hw_shutdown_n(hw_shutdown_n),
		.power_on_request(power_on_request), .button_press_n(button_press_n),
		.rail_in_reg(rail_in_reg), .irq_ctl({irq_set, irq_mask, host_ack}),
		.irq_flags(irq_flags), .irq_request_n_out(irq_out),
		.irq_request_n_oe(irq_oe), .wake_indication_n_out(wake_out),
		.wake_indication_n_oe(wake_oe), .all_rails_good(all_good),
		.linear_regs_good(lin_good), .rail_enable(rail_enable),
		.button_pressed(btn), .defaults_load(dflt));

	pmsup_host_model host (.core_clk(core_clk), .rst_n(rst_n),
		.irq_line(irq_line), .reading(reading), .delay(dly),
		.flags(irq_flags), .read_ack(host_ack));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic test_done();
		if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done

	task automatic check(input logic [20:0] seen, input logic [20:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic note(input logic [20:0] mk, input logic [20:0] v);
		notes.push_back({mk, v & mk});
	endtask : note

	// Bounded wait on settled outputs; running out of time is a mismatch.
	task automatic wait_obs(input logic [20:0] mk, v, input int lim,
		output int cnt);
		cnt = 0;
		do begin
			@(negedge core_clk);
			cnt++;
			if (cnt > lim) begin
				n_mismatch++;
				test_done();
			end
		end while ((obs & mk) !== v);
	endtask : wait_obs

	// Clock at 100 MHz.
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Outputs settle by the falling edge, so each note is judged there.
	always @(negedge core_clk) begin
		while (notes.size() > 0) begin
			nt = notes.pop_front();
			check(obs & nt[41:21], nt[20:0]);
		end
	end

	// Main sequence: power-up, rails, button, interrupts, shutdown.
	initial begin
		seed = 32'hF945;
		rst_n = 1'b0;
		hw_shutdown_n = 1'b1;
		power_on_request = 1'b0;
		button_press_n = 1'b1;
		rail_in_reg = 7'h7F;
		irq_set = '0;
		irq_mask = '0;
		reading = 1'b0;
		dly = '0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		note(M_ALL, 21'h1);
		@(posedge core_clk) irq_set <= 8'hFF;
		@(posedge core_clk) irq_set <= '0;
		note(M_FLG | M_IRQ, '0);
		@(posedge core_clk) power_on_request <= 1'b1;
		wait_obs(M_RAIL | M_WAKE | M_ALL, 21'h9FC | 21'h600, 8, n);
		check(obs & (M_WAKE | 21'h1), M_WAKE);
		check(21'(wake_line), '0);
		repeat (8) begin
			r = rnd();
			@(posedge core_clk) rail_in_reg <= r[6:0];
			@(posedge core_clk);
			note(M_AG | M_LG, 21'({&r[6:0], r[3] & r[4]}) << 9);
		end
		@(posedge core_clk) rail_in_reg <= 7'h7F;
		@(posedge core_clk) button_press_n <= 1'b0;
		wait_obs(M_BTN, M_BTN, 6, n);
		check(21'(n), 21'h4);
		@(posedge core_clk) button_press_n <= 1'b1;
		wait_obs(M_BTN, '0, 6, n);
		check(21'(n), 21'h4);
		repeat (3) begin
			r = rnd();
			m = r[15:8] & 8'hFE;
			s = r[7:0] | 8'h01;
			@(posedge core_clk) irq_mask <= m;
			irq_set <= s;
			@(posedge core_clk) irq_set <= '0;
			note(M_FLG | M_IRQ, {s, 1'b1, 12'h0});
			@(negedge core_clk) check(21'(irq_line), '0);
			f = s;
			dly <= r[19:16];
			reading <= 1'b1;
			while ((f & ~m) != '0) begin
				f = f & (f - 8'h01);
				wait_obs(M_FLG, 21'(f) << 13, 60, n);
				note(M_IRQ, 21'(|(f & ~m)) << 12);
			end
			note(M_FLG | M_IRQ | M_WAKE, 21'(f) << 13);
			@(posedge core_clk) irq_mask <= '0;
			@(posedge core_clk);
			note(M_IRQ, 21'(|f) << 12);
			wait_obs(M_FLG | M_IRQ, '0, 300, n);
			@(posedge core_clk) reading <= 1'b0;
		end
		// A set on a source masked one cycle earlier must stay quiet.
		@(posedge core_clk) irq_mask <= 8'h80;
		@(posedge core_clk) irq_set <= 8'h80;
		@(posedge core_clk) irq_set <= '0;
		hw_shutdown_n <= 1'b0;
		note(M_FLG | M_IRQ, 21'h100000);
		wait_obs(M_ALL, 21'h1, 8, n);
		repeat (RC + 10) @(posedge core_clk);
		note(M_ALL, 21'h1);
		@(posedge core_clk) hw_shutdown_n <= 1'b1;
		wait_obs(M_RAIL, M_RAIL, RC + 20, n);
		check(21'(n >= RC && n <= RC + 8), 21'h1);
		@(posedge core_clk);
		note(M_WAKE | M_FLG | 21'h1, M_WAKE);
		@(negedge core_clk);
		@(negedge core_clk);
		test_done();
	end
endmodule : pmsup_pins_bench
